// file: mbr_cfg.svh
// constants of the modbus slave id router
`ifndef MBR_CFG_SVH
`define MBR_CFG_SVH
`define MBR_NCH 4
`define MBR_NPR 4
`define MBR_ID_MIN 8'h01
`define MBR_ID_MAX 8'hFE
`define MBR_ID_GW 8'hFF
`define MBR_OFS_MAX 9'sd253
`define MBR_TCP_DFLT 16'h07D1
// register byte addresses
`define MBR_A_CTRL 8'h00
`define MBR_A_STAT 8'h04
`define MBR_A_DROP 8'h08
`define MBR_A_CH0 8'h40
`define MBR_A_CHX0 8'h60
`define MBR_A_PR0 8'h80
`define MBR_A_PRX0 8'hA0
// field positions
`define MBR_CH_LO 0
`define MBR_CH_HI 8
`define MBR_CH_OFS 16
`define MBR_CH_EN 31
`define MBR_CTRL_AUTO 0
`define MBR_AUTO_RST 1'b1
`define MBR_CH_PORT 0
`define MBR_CH_TCP 2
`define MBR_CH_PROTO 4
`define MBR_PR_TCP 4
`define MBR_PR_EN 31
`endif

// file: mbr_pkg.sv
// types of the modbus slave id router
package mbr_pkg;
  // one slave id channel
  typedef struct packed {
    logic en;
    logic [1:0] proto;
    logic is_tcp;
    logic [1:0] port;
    logic [8:0] ofs;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [31:0] ip;
  } mbr_chan_t;
  // one port routing entry
  typedef struct packed {
    logic en;
    logic by_tcp;
    logic [1:0] port;
    logic [31:0] key;
  } mbr_prt_t;
  // request arriving from the tcp side
  typedef struct packed {
    logic [7:0] id;
    logic [31:0] lip;
    logic [15:0] lport;
    logic [15:0] tag;
  } mbr_req_t;
  // routed request
  typedef struct packed {
    logic [7:0] id;
    logic is_tcp;
    logic [1:0] port;
    logic [31:0] ip;
    logic [15:0] tag;
  } mbr_fwd_t;
  typedef enum logic [1:0] {
    MBR_IDLE = 2'b01,
    MBR_BUSY = 2'b10
  } mbr_st_t;
endpackage

// file: mbr_router.sv
// modbus slave id router with wishbone configuration
// How it works
// - each channel holds a virtual id range, bounds within 1 to 254.
// - id 255 belongs to the gateway and no channel routes it; a port table match still forwards it.
// - each channel has a signed offset limited to -253 to 253.
// - real id equals virtual id plus the channel offset.
// - requests matching no channel range and no port entry are dropped, never forwarded.
// - a matched request goes to exactly one destination.
// - a channel match forwards the translated real id, a port table match the id unchanged.
// - channels hold protocol, range pair and destination, all rewritable.
// - serial slave mode creates a default channel for that port.
// - a channel may target one remote tcp slave ip address.
// - second table selects serial port by local ip or tcp port.
// - request on mapped local tcp port goes to its serial port.
// - request to mapped local ip goes to its serial port.
`timescale 1ns/1ps
`include "mbr_cfg.svh"
module mbr_router import mbr_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial slave mode per port
  input wire logic [`MBR_NPR-1:0] slave_mode_i,
  // request stream
  input wire logic req_valid_i,
  output logic req_ready_o,
  input mbr_req_t req_i,
  // forwarded stream
  output logic fwd_valid_o,
  input wire logic fwd_ready_i,
  output mbr_fwd_t fwd_o,
  // drop pulse
  output logic drop_o
);

  // ----------------------------------------------------------------
  // configuration tables
  // ----------------------------------------------------------------
  mbr_chan_t chan_q [`MBR_NCH];
  mbr_prt_t prt_q [`MBR_NPR];
  logic auto_q;
  logic [15:0] drop_cnt_q;
  logic [31:0] fwd_cnt_q;
  logic [`MBR_NPR-1:0] mode_seen_q;

  // byte lane merge for writes
  function automatic logic [31:0] mbr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // clamp a range bound into the routable window
  function automatic logic [7:0] mbr_clamp(input logic [7:0] v);
    if (v < `MBR_ID_MIN) begin
      return `MBR_ID_MIN;
    end
    if (v > `MBR_ID_MAX) begin
      return `MBR_ID_MAX;
    end
    return v;
  endfunction

  // clamp an offset to the legal signed span
  function automatic logic [8:0] mbr_oclamp(input logic [8:0] v);
    if ($signed(v) > `MBR_OFS_MAX) begin
      return 9'h0FD;
    end
    if ($signed(v) < -`MBR_OFS_MAX) begin
      return 9'h103;
    end
    return v;
  endfunction

  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_q <= `MBR_AUTO_RST;
    end else if (wb_wr && wb_adr_i == `MBR_A_CTRL) begin
      auto_q <= wb_dat_i[`MBR_CTRL_AUTO];
    end
  end

  // slave id channels, writable any time
  genvar gc;
  generate
    for (gc = 0; gc < `MBR_NCH; gc++) begin : g_ch
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] m0;
      logic [31:0] m1;
      logic hit0;
      logic hit1;
      assign w0 = {chan_q[gc].en, 6'h00, chan_q[gc].ofs, chan_q[gc].hi, chan_q[gc].lo};
      assign w1 = chan_q[gc].ip;
      assign m0 = mbr_merge(w0, wb_dat_i, wb_sel_i);
      assign m1 = mbr_merge(w1, wb_dat_i, wb_sel_i);
      assign hit0 = wb_wr && wb_adr_i == (`MBR_A_CH0 + 8'(gc * 8));
      assign hit1 = wb_wr && wb_adr_i == (`MBR_A_CHX0 + 8'(gc * 8));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          chan_q[gc] <= '0;
        end else if (hit0) begin
          chan_q[gc].lo <= mbr_clamp(m0[`MBR_CH_LO +: 8]);
          chan_q[gc].hi <= mbr_clamp(m0[`MBR_CH_HI +: 8]);
          chan_q[gc].ofs <= mbr_oclamp(m0[`MBR_CH_OFS +: 9]);
          chan_q[gc].en <= m0[`MBR_CH_EN];
        end else if (hit1) begin
          chan_q[gc].ip <= m1;
        end else if (wb_wr && wb_adr_i == (`MBR_A_CH0 + 8'(gc * 8) + 8'h04)) begin
          chan_q[gc].proto <= wb_dat_i[`MBR_CH_PROTO +: 2];
          chan_q[gc].is_tcp <= wb_dat_i[`MBR_CH_TCP];
          chan_q[gc].port <= wb_dat_i[`MBR_CH_PORT +: 2];
        end else if (gc < `MBR_NPR && auto_q && slave_mode_i[gc % `MBR_NPR]
                     && !mode_seen_q[gc % `MBR_NPR]) begin
          chan_q[gc].en <= 1'b1;
          chan_q[gc].lo <= 8'(gc * 5 + 1);
          chan_q[gc].hi <= 8'(gc * 5 + 5);
          chan_q[gc].ofs <= 9'h000;
          chan_q[gc].is_tcp <= 1'b0;
          chan_q[gc].port <= 2'(gc);
        end
      end
    end
  endgenerate

  // remember each port's slave mode from the previous cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_seen_q <= '0;
    end else begin
      mode_seen_q <= slave_mode_i;
    end
  end

  // port routing table
  genvar gp;
  generate
    for (gp = 0; gp < `MBR_NPR; gp++) begin : g_pr
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prt_q[gp] <= '0;
        end else if (wb_wr && wb_adr_i == (`MBR_A_PR0 + 8'(gp * 4))) begin
          prt_q[gp].key <= mbr_merge(prt_q[gp].key, wb_dat_i, wb_sel_i);
        end else if (wb_wr && wb_adr_i == (`MBR_A_PRX0 + 8'(gp * 4))) begin
          prt_q[gp].en <= wb_dat_i[`MBR_PR_EN];
          prt_q[gp].by_tcp <= wb_dat_i[`MBR_PR_TCP];
          prt_q[gp].port <= wb_dat_i[`MBR_CH_PORT +: 2];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // lookup
  // ----------------------------------------------------------------
  logic ch_hit;
  logic pr_hit;
  mbr_fwd_t look;
  logic [8:0] sum;
  always_comb begin
    ch_hit = 1'b0;
    pr_hit = 1'b0;
    sum = 9'h000;
    look = '0;
    look.tag = req_i.tag;
    look.id = req_i.id;
    if (req_i.id != `MBR_ID_GW) begin
      for (int i = `MBR_NCH - 1; i >= 0; i--) begin
        if (chan_q[i].en && req_i.id >= chan_q[i].lo && req_i.id <= chan_q[i].hi) begin
          ch_hit = 1'b1;
          sum = {1'b0, req_i.id} + chan_q[i].ofs;
          look.id = sum[7:0];
          look.is_tcp = chan_q[i].is_tcp;
          look.ip = chan_q[i].ip;
          look.port = chan_q[i].port;
        end
      end
    end
    // second table by ip or tcp port
    for (int j = `MBR_NPR - 1; j >= 0; j--) begin
      if (prt_q[j].en && (prt_q[j].by_tcp ? req_i.lport == prt_q[j].key[15:0]
                                           : req_i.lip == prt_q[j].key)) begin
        pr_hit = 1'b1;
        look.port = prt_q[j].port;
      end
    end
    if (pr_hit) begin
      look.is_tcp = 1'b0;
      look.ip = '0;
      look.id = req_i.id;
    end
  end

  // ----------------------------------------------------------------
  // two entry output buffer
  // ----------------------------------------------------------------
  mbr_fwd_t buf_q [2];
  logic [1:0] cnt_q;
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic take;
  logic push;
  logic pop;
  logic routed;
  assign routed = ch_hit | pr_hit;
  assign req_ready_o = cnt_q != 2'd2;
  assign take = req_valid_i & req_ready_o;
  assign push = take & routed;
  assign pop = fwd_valid_o & fwd_ready_i;
  assign fwd_valid_o = cnt_q != 2'd0;
  assign fwd_o = buf_q[rd_ptr_q];

  // buffer storage, flip-flops indexed by pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[wr_ptr_q] <= look;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'd0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
    end
  end

  // statistics, drop pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_o <= 1'b0;
      drop_cnt_q <= '0;
      fwd_cnt_q <= '0;
    end else begin
      drop_o <= take & ~routed;
      if (take & ~routed) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
      if (pop) begin
        fwd_cnt_q <= fwd_cnt_q + 32'h00000001;
      end
    end
  end

  // read mux, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= '0;
      case (wb_adr_i)
        `MBR_A_CTRL: wb_dat_o <= {31'h0, auto_q};
        `MBR_A_STAT: wb_dat_o <= {28'h0, slave_mode_i & 4'hF};
        `MBR_A_DROP: wb_dat_o <= {drop_cnt_q, 16'h0};
        default: begin
          for (int i = 0; i < `MBR_NCH; i++) begin
            if (wb_adr_i == `MBR_A_CH0 + 8'(i * 8)) begin
              wb_dat_o <= {chan_q[i].en, 6'h00, chan_q[i].ofs, chan_q[i].hi, chan_q[i].lo};
            end
            if (wb_adr_i == `MBR_A_CH0 + 8'(i * 8) + 8'h04) begin
              wb_dat_o <= {26'h0, chan_q[i].proto, 1'b0, chan_q[i].is_tcp, chan_q[i].port};
            end
            if (wb_adr_i == `MBR_A_CHX0 + 8'(i * 8)) begin
              wb_dat_o <= chan_q[i].ip;
            end
          end
          for (int j = 0; j < `MBR_NPR; j++) begin
            if (wb_adr_i == `MBR_A_PR0 + 8'(j * 4)) begin
              wb_dat_o <= prt_q[j].key;
            end
            if (wb_adr_i == `MBR_A_PRX0 + 8'(j * 4)) begin
              wb_dat_o <= {prt_q[j].en, 26'h0, prt_q[j].by_tcp, 2'h0, prt_q[j].port};
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_drop_unmatched: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !routed |=> drop_o && ($stable(cnt_q) || $past(pop)))
    else $error("unmatched request not dropped");
  a_gw_id_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    take && req_i.id == `MBR_ID_GW && !pr_hit |=> drop_o)
    else $error("gateway id was routed");
  a_full_stalls: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q == 2'd2 && !fwd_ready_i |=> cnt_q == 2'd2 && !req_ready_o)
    else $error("buffer full but ready");
  a_pass_ordered: assert property (@(posedge clk_i) disable iff (rst_i)
    push && cnt_q == 2'd0 |=> fwd_valid_o && fwd_o == $past(look))
    else $error("forwarded word differs");
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ofs_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    $signed(chan_q[0].ofs) <= `MBR_OFS_MAX && $signed(chan_q[0].ofs) >= -`MBR_OFS_MAX)
    else $error("offset out of span");
  a_lo_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    chan_q[0].en |-> chan_q[0].lo >= `MBR_ID_MIN && chan_q[0].hi <= `MBR_ID_MAX)
    else $error("bound out of span");
  a_cnt_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q <= 2'd2)
    else $error("fill count overflow");
  c_forward: cover property (@(posedge clk_i) disable iff (rst_i) pop);
  c_drop: cover property (@(posedge clk_i) disable iff (rst_i) drop_o);
  c_full: cover property (@(posedge clk_i) disable iff (rst_i) cnt_q == 2'd2);
  c_port_route: cover property (@(posedge clk_i) disable iff (rst_i) push && pr_hit);

endmodule // mbr_router

// file: mbr_sink.sv
// far side model of the forwarded stream
`timescale 1ns/1ps
module mbr_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // 0 ready, 1 random stall, 2 hold off
  input wire logic [1:0] mode_i,
  // stream
  input wire logic fwd_valid_i,
  output logic fwd_ready_o
);
  // ready moves only after a rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_ready_o <= 1'b0;
    end else begin
      case (mode_i)
        2'd0: fwd_ready_o <= 1'b1;
        2'd1: fwd_ready_o <= 1'($urandom_range(0, 1));
        default: fwd_ready_o <= 1'b0;
      endcase
    end
  end
endmodule // mbr_sink

// file: testbench.sv
// self-checking bench of the modbus slave id router
`timescale 1ns/1ps
`include "mbr_cfg.svh"
module testbench import mbr_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, req_valid_i = 1'b0, req_ready_o, fwd_valid_o, fwd_ready_i, drop_o;
  logic [`MBR_NPR-1:0] slave_mode_i = '0;
  logic [1:0] mode = 2'd0;
  mbr_req_t req_i = '0;
  mbr_fwd_t fwd_o;
  int errors = 0, checked = 0;
  logic [31:0] rq[$];
  mbr_fwd_t fq[$];
  bit dq[$];
  mbr_router dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slave_mode_i(slave_mode_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
    .fwd_valid_o(fwd_valid_o), .fwd_ready_i(fwd_ready_i), .fwd_o(fwd_o), .drop_o(drop_o));
  mbr_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .fwd_valid_i(fwd_valid_o),
    .fwd_ready_o(fwd_ready_i));
  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) bad($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic cmp_fwd(input mbr_fwd_t got, input mbr_fwd_t exp);
    logic ok;
    checked++;
    ok = got.id === exp.id && got.is_tcp === exp.is_tcp && got.port === exp.port;
    ok = ok && got.tag === exp.tag && (!exp.is_tcp || got.ip === exp.ip);
    if (!ok) bad($sformatf("forward %h expected %h", got, exp));
  endtask
  task automatic cmp_drop;
    checked++;
    if (dq.size() == 0) bad("stray drop");
    else void'(dq.pop_front());
  endtask
  // classic cycle, held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    logic a;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    a = 1'b0;
    for (int n = 0; n < 20 && !a; n++) begin
      @(posedge clk_i);
      a = (wb_ack_o === 1'b1);
    end
    if (!a) begin
      bad("no ack");
      report_and_stop();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rq.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask
  // request held until taken; caller releases valid by idle
  task automatic send(input logic [7:0] id, input logic [31:0] lip, input logic [15:0] lp,
      input logic rt, input logic [7:0] eid, input logic tcp, input logic [1:0] prt,
      input logic [31:0] eip);
    logic a;
    logic [15:0] tg;
    tg = 16'($urandom);
    if (rt) fq.push_back('{id: eid, is_tcp: tcp, port: prt, ip: eip, tag: tg});
    else dq.push_back(1'b1);
    req_i <= '{id: id, lip: lip, lport: lp, tag: tg};
    req_valid_i <= 1'b1;
    a = 1'b0;
    for (int n = 0; n < 300 && !a; n++) begin
      @(posedge clk_i);
      a = (req_ready_o === 1'b1);
    end
    if (!a) begin
      bad("request never taken");
      report_and_stop();
    end
  endtask
  task automatic idle;
    req_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  // sampled at the rising edge, before that edge's updates land
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rq.size() == 0) bad("stray read");
      else cmp_val(wb_dat_o, rq.pop_front());
    end
    if (fwd_valid_o === 1'b1 && fwd_ready_i === 1'b1) begin
      if (fq.size() == 0) bad("stray forward");
      else cmp_fwd(fwd_o, fq.pop_front());
    end
    if (drop_o === 1'b1) cmp_drop();
  end
  // watchdog counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_i);
    bad("timeout");
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hFABE));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`MBR_A_CTRL, 32'h1);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0);
    send(8'h08, 32'h0, 16'h0, 1'b0, 8'h0, 1'b0, 2'd0, 32'h0);
    idle();
    slave_mode_i <= 4'b0010;
    repeat (3) @(posedge clk_i);
    rd(8'h48, 32'h8000_0A06);
    rd(`MBR_A_STAT, 32'h2);
    send(8'h08, 32'h0, 16'h0, 1'b1, 8'h08, 1'b0, 2'd1, 32'h0);
    idle();
    wb(1'b1, 8'h44, 32'h0);
    wb(1'b1, 8'h40, 32'h81EF_1614);
    // offset -17 on both ends, back to back
    send(8'h14, 32'h0, 16'h0, 1'b1, 8'h03, 1'b0, 2'd0, 32'h0);
    send(8'h16, 32'h0, 16'h0, 1'b1, 8'h05, 1'b0, 2'd0, 32'h0);
    send(8'h17, 32'h0, 16'h0, 1'b0, 8'h0, 1'b0, 2'd0, 32'h0);
    send(8'h13, 32'h0, 16'h0, 1'b0, 8'h0, 1'b0, 2'd0, 32'h0);
    idle();
    wb(1'b1, 8'h5C, 32'h34);
    wb(1'b1, 8'h78, 32'hC0A8_0105);
    wb(1'b1, 8'h58, 32'h8000_1F1E);
    send(8'h1F, 32'h0, 16'h0, 1'b1, 8'h1F, 1'b1, 2'd0, 32'hC0A8_0105);
    idle();
    rd(8'h5C, 32'h34);
    // byte lane merge on the remote address word
    wb_sel_i <= 4'h1;
    wb(1'b1, 8'h78, 32'h0000_0077);
    wb_sel_i <= 4'hF;
    rd(8'h78, 32'hC0A8_0177);
    wb(1'b1, 8'h54, 32'h2);
    // bounds and offset written out of span read back clamped
    wb(1'b1, 8'h50, 32'h0100_FF00);
    rd(8'h50, 32'h0103_FE01);
    wb(1'b1, 8'h50, 32'h8100_FFF0);
    send(8'hFF, 32'h0, 16'h0, 1'b0, 8'h0, 1'b0, 2'd0, 32'h0);
    send(8'hF0, 32'h0, 16'h0, 1'b1, 8'hF3, 1'b0, 2'd2, 32'h0);
    idle();
    wb(1'b1, 8'h80, 32'h0000_07D1);
    wb(1'b1, 8'hA0, 32'h8000_0013);
    wb(1'b1, 8'h84, 32'hC0A8_0101);
    wb(1'b1, 8'hA4, 32'h8000_0002);
    send(8'h14, 32'h0, 16'h07D1, 1'b1, 8'h14, 1'b0, 2'd3, 32'h0);
    send(8'h14, 32'hC0A8_0101, 16'h0, 1'b1, 8'h14, 1'b0, 2'd2, 32'h0);
    idle();
    wb(1'b1, 8'h40, 32'h8000_1614);
    send(8'h15, 32'h0, 16'h0, 1'b1, 8'h15, 1'b0, 2'd0, 32'h0);
    idle();
    // two entries then refuse while the far side holds off
    mode <= 2'd2;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 2; i++) send(8'h14, 32'h0, 16'h0, 1'b1, 8'h14, 1'b0, 2'd0, 32'h0);
    idle();
    @(negedge clk_i);
    cmp_val({30'h0, req_ready_o, fwd_valid_o}, 32'h1);
    @(posedge clk_i);
    mode <= 2'd1;
    for (int i = 0; i < 20; i++) begin
      logic [7:0] v;
      v = 8'h14 + 8'($urandom_range(0, 2));
      send(v, 32'h0, 16'h0, 1'b1, v, 1'b0, 2'd0, 32'h0);
    end
    idle();
    mode <= 2'd0;
    for (int n = 0; n < 200 && fq.size() != 0; n++) @(posedge clk_i);
    if (fq.size() != 0 || dq.size() != 0) bad("results missing");
    // no default channel with auto off
    wb(1'b1, `MBR_A_CTRL, 32'h0);
    slave_mode_i <= 4'b0011;
    repeat (3) @(posedge clk_i);
    rd(8'h40, 32'h8000_1614);
    rd(`MBR_A_DROP, 32'h0004_0000);
    report_and_stop();
  end
endmodule // testbench
